// *** core/port_bank_pkg.sv ***
/*
  constants for the port output latch and pull-up bank: register byte
  offsets, port widths and reset values.
  assumes an 8-bit register bus with a 16-bit byte address.
*/
package port_bank_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // port widths in pins
  localparam int W_PORT_1 = 8;
  localparam int W_PORT_2 = 8;
  localparam int W_PORT_3 = 6;
  localparam int W_PORT_A = 4;
  localparam int W_PORT_B = 8;
  localparam int W_PORT_C = 8;
  localparam int W_PORT_D = 8;
  localparam int W_PORT_E = 8;
  localparam int W_PORT_F = 8;
  localparam int W_PORT_G = 5;

  // register byte offsets
  localparam logic [15:0] OFS_PORT_G_PIN_STATE = 16'hff5f;
  localparam logic [15:0] OFS_PORT_1_OUTPUT_LATCH = 16'hff60;
  localparam logic [15:0] OFS_PORT_2_OUTPUT_LATCH = 16'hff61;
  localparam logic [15:0] OFS_PORT_3_OUTPUT_LATCH = 16'hff62;
  localparam logic [15:0] OFS_PORT_A_OUTPUT_LATCH = 16'hff69;
  localparam logic [15:0] OFS_PORT_B_OUTPUT_LATCH = 16'hff6a;
  localparam logic [15:0] OFS_PORT_C_OUTPUT_LATCH = 16'hff6b;
  localparam logic [15:0] OFS_PORT_D_OUTPUT_LATCH = 16'hff6c;
  localparam logic [15:0] OFS_PORT_E_OUTPUT_LATCH = 16'hff6d;
  localparam logic [15:0] OFS_PORT_F_OUTPUT_LATCH = 16'hff6e;
  localparam logic [15:0] OFS_PORT_G_OUTPUT_LATCH = 16'hff6f;
  localparam logic [15:0] OFS_PORT_A_PULLUP_CONTROL = 16'hff70;
  localparam logic [15:0] OFS_PORT_B_PULLUP_CONTROL = 16'hff71;
  localparam logic [15:0] OFS_PORT_C_PULLUP_CONTROL = 16'hff72;
  localparam logic [15:0] OFS_PORT_D_PULLUP_CONTROL = 16'hff73;

  // reset values
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

endpackage : port_bank_pkg

// *** core/port_latch_reg.sv ***
/*
  one software-written latch of a port: a W-bit register at one byte
  offset, cleared by reset, written whole by a bus write strobe.
  assumes the bus address and data are synchronous to core_clk.
*/
`timescale 1ns/1ps
module port_latch_reg #(
  parameter int W = 8,
  parameter logic [15:0] OFFSET = 16'h0000
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [port_bank_pkg::ADDR_W-1:0] addr,
  input wire logic [port_bank_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  output logic [W-1:0] q,
  output logic [port_bank_pkg::DATA_W-1:0] rd_view
);
  import port_bank_pkg::*;

  typedef struct packed {
    logic [W-1:0] q;
  } latch_state_t;

  latch_state_t st_r;
  latch_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr && addr == OFFSET) begin
      st_nxt.q = wdata[W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r.q <= LATCH_RESET[W-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
  // unimplemented upper bits read as zero
  assign rd_view = DATA_W'(st_r.q);

endmodule : port_latch_reg

// *** core/port_output_latch_and_pullup_bank.sv ***
/*
  output data latches of ports 1, 2, 3, a..g, the port g pin-state read
  and the pull-up controls of ports a..d, behind a plain register port.
  assumes direction bits come from elsewhere as levels, pins are
  synchronous to core_clk, and the pad cells use out/oe/pullup.
*/
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module port_output_latch_and_pullup_bank (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [port_bank_pkg::ADDR_W-1:0] addr,
  input wire logic [port_bank_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [port_bank_pkg::DATA_W-1:0] rdata,
  input wire logic [port_bank_pkg::W_PORT_G-1:0] port_g_pin_in,
  input wire logic [port_bank_pkg::W_PORT_1-1:0] port_1_dir,
  input wire logic [port_bank_pkg::W_PORT_2-1:0] port_2_dir,
  input wire logic [port_bank_pkg::W_PORT_3-1:0] port_3_dir,
  input wire logic [port_bank_pkg::W_PORT_A-1:0] port_a_dir,
  input wire logic [port_bank_pkg::W_PORT_B-1:0] port_b_dir,
  input wire logic [port_bank_pkg::W_PORT_C-1:0] port_c_dir,
  input wire logic [port_bank_pkg::W_PORT_D-1:0] port_d_dir,
  input wire logic [port_bank_pkg::W_PORT_E-1:0] port_e_dir,
  input wire logic [port_bank_pkg::W_PORT_F-1:0] port_f_dir,
  input wire logic [port_bank_pkg::W_PORT_G-1:0] port_g_dir,
  output logic [port_bank_pkg::W_PORT_1-1:0] port_1_out,
  output logic [port_bank_pkg::W_PORT_2-1:0] port_2_out,
  output logic [port_bank_pkg::W_PORT_3-1:0] port_3_out,
  output logic [port_bank_pkg::W_PORT_A-1:0] port_a_out,
  output logic [port_bank_pkg::W_PORT_B-1:0] port_b_out,
  output logic [port_bank_pkg::W_PORT_C-1:0] port_c_out,
  output logic [port_bank_pkg::W_PORT_D-1:0] port_d_out,
  output logic [port_bank_pkg::W_PORT_E-1:0] port_e_out,
  output logic [port_bank_pkg::W_PORT_F-1:0] port_f_out,
  output logic [port_bank_pkg::W_PORT_G-1:0] port_g_out,
  output logic [port_bank_pkg::W_PORT_1-1:0] port_1_oe,
  output logic [port_bank_pkg::W_PORT_2-1:0] port_2_oe,
  output logic [port_bank_pkg::W_PORT_3-1:0] port_3_oe,
  output logic [port_bank_pkg::W_PORT_A-1:0] port_a_oe,
  output logic [port_bank_pkg::W_PORT_B-1:0] port_b_oe,
  output logic [port_bank_pkg::W_PORT_C-1:0] port_c_oe,
  output logic [port_bank_pkg::W_PORT_D-1:0] port_d_oe,
  output logic [port_bank_pkg::W_PORT_E-1:0] port_e_oe,
  output logic [port_bank_pkg::W_PORT_F-1:0] port_f_oe,
  output logic [port_bank_pkg::W_PORT_G-1:0] port_g_oe,
  output logic [port_bank_pkg::W_PORT_A-1:0] port_a_pullup_en,
  output logic [port_bank_pkg::W_PORT_B-1:0] port_b_pullup_en,
  output logic [port_bank_pkg::W_PORT_C-1:0] port_c_pullup_en,
  output logic [port_bank_pkg::W_PORT_D-1:0] port_d_pullup_en
);
  import port_bank_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [W_PORT_1-1:0] out_1;
    logic [W_PORT_2-1:0] out_2;
    logic [W_PORT_3-1:0] out_3;
    logic [W_PORT_A-1:0] out_a;
    logic [W_PORT_B-1:0] out_b;
    logic [W_PORT_C-1:0] out_c;
    logic [W_PORT_D-1:0] out_d;
    logic [W_PORT_E-1:0] out_e;
    logic [W_PORT_F-1:0] out_f;
    logic [W_PORT_G-1:0] out_g;
    logic [W_PORT_1-1:0] oe_1;
    logic [W_PORT_2-1:0] oe_2;
    logic [W_PORT_3-1:0] oe_3;
    logic [W_PORT_A-1:0] oe_a;
    logic [W_PORT_B-1:0] oe_b;
    logic [W_PORT_C-1:0] oe_c;
    logic [W_PORT_D-1:0] oe_d;
    logic [W_PORT_E-1:0] oe_e;
    logic [W_PORT_F-1:0] oe_f;
    logic [W_PORT_G-1:0] oe_g;
    logic [W_PORT_A-1:0] pu_a;
    logic [W_PORT_B-1:0] pu_b;
    logic [W_PORT_C-1:0] pu_c;
    logic [W_PORT_D-1:0] pu_d;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  logic [W_PORT_1-1:0] lat_1;
  logic [W_PORT_2-1:0] lat_2;
  logic [W_PORT_3-1:0] lat_3;
  logic [W_PORT_A-1:0] lat_a;
  logic [W_PORT_B-1:0] lat_b;
  logic [W_PORT_C-1:0] lat_c;
  logic [W_PORT_D-1:0] lat_d;
  logic [W_PORT_E-1:0] lat_e;
  logic [W_PORT_F-1:0] lat_f;
  logic [W_PORT_G-1:0] lat_g;
  logic [W_PORT_A-1:0] pcr_a;
  logic [W_PORT_B-1:0] pcr_b;
  logic [W_PORT_C-1:0] pcr_c;
  logic [W_PORT_D-1:0] pcr_d;
  logic [DATA_W-1:0] v_1, v_2, v_3, v_a, v_b, v_c, v_d, v_e, v_f, v_g;
  logic [DATA_W-1:0] v_pa, v_pb, v_pc, v_pd;

  // output data latches
  port_latch_reg #(.W(W_PORT_1), .OFFSET(OFS_PORT_1_OUTPUT_LATCH)) u_lat_1 (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_1),
    .rd_view(v_1)
  );

  port_latch_reg #(.W(W_PORT_2), .OFFSET(OFS_PORT_2_OUTPUT_LATCH)) u_lat_2 (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_2),
    .rd_view(v_2)
  );

  port_latch_reg #(.W(W_PORT_3), .OFFSET(OFS_PORT_3_OUTPUT_LATCH)) u_lat_3 (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_3),
    .rd_view(v_3)
  );

  port_latch_reg #(.W(W_PORT_A), .OFFSET(OFS_PORT_A_OUTPUT_LATCH)) u_lat_a (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_a),
    .rd_view(v_a)
  );

  port_latch_reg #(.W(W_PORT_B), .OFFSET(OFS_PORT_B_OUTPUT_LATCH)) u_lat_b (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_b),
    .rd_view(v_b)
  );

  port_latch_reg #(.W(W_PORT_C), .OFFSET(OFS_PORT_C_OUTPUT_LATCH)) u_lat_c (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_c),
    .rd_view(v_c)
  );

  port_latch_reg #(.W(W_PORT_D), .OFFSET(OFS_PORT_D_OUTPUT_LATCH)) u_lat_d (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_d),
    .rd_view(v_d)
  );

  port_latch_reg #(.W(W_PORT_E), .OFFSET(OFS_PORT_E_OUTPUT_LATCH)) u_lat_e (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_e),
    .rd_view(v_e)
  );

  port_latch_reg #(.W(W_PORT_F), .OFFSET(OFS_PORT_F_OUTPUT_LATCH)) u_lat_f (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_f),
    .rd_view(v_f)
  );

  port_latch_reg #(.W(W_PORT_G), .OFFSET(OFS_PORT_G_OUTPUT_LATCH)) u_lat_g (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(lat_g),
    .rd_view(v_g)
  );

  // pull-up controls
  port_latch_reg #(.W(W_PORT_A), .OFFSET(OFS_PORT_A_PULLUP_CONTROL)) u_pcr_a (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(pcr_a),
    .rd_view(v_pa)
  );

  port_latch_reg #(.W(W_PORT_B), .OFFSET(OFS_PORT_B_PULLUP_CONTROL)) u_pcr_b (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(pcr_b),
    .rd_view(v_pb)
  );

  port_latch_reg #(.W(W_PORT_C), .OFFSET(OFS_PORT_C_PULLUP_CONTROL)) u_pcr_c (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(pcr_c),
    .rd_view(v_pc)
  );

  port_latch_reg #(.W(W_PORT_D), .OFFSET(OFS_PORT_D_PULLUP_CONTROL)) u_pcr_d (
    .core_clk(core_clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .q(pcr_d),
    .rd_view(v_pd)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = READ_IDLE;
    if (rd) begin
      case (addr)
        // sampled straight from the pins at the read, never stored
        OFS_PORT_G_PIN_STATE: st_nxt.rdata = DATA_W'({3'h0, port_g_pin_in});
        OFS_PORT_1_OUTPUT_LATCH: st_nxt.rdata = v_1;
        OFS_PORT_2_OUTPUT_LATCH: st_nxt.rdata = v_2;
        OFS_PORT_3_OUTPUT_LATCH: st_nxt.rdata = v_3;
        OFS_PORT_A_OUTPUT_LATCH: st_nxt.rdata = v_a;
        OFS_PORT_B_OUTPUT_LATCH: st_nxt.rdata = v_b;
        OFS_PORT_C_OUTPUT_LATCH: st_nxt.rdata = v_c;
        OFS_PORT_D_OUTPUT_LATCH: st_nxt.rdata = v_d;
        OFS_PORT_E_OUTPUT_LATCH: st_nxt.rdata = v_e;
        OFS_PORT_F_OUTPUT_LATCH: st_nxt.rdata = v_f;
        OFS_PORT_G_OUTPUT_LATCH: st_nxt.rdata = v_g;
        OFS_PORT_A_PULLUP_CONTROL: st_nxt.rdata = v_pa;
        OFS_PORT_B_PULLUP_CONTROL: st_nxt.rdata = v_pb;
        OFS_PORT_C_PULLUP_CONTROL: st_nxt.rdata = v_pc;
        OFS_PORT_D_PULLUP_CONTROL: st_nxt.rdata = v_pd;
        default: st_nxt.rdata = READ_IDLE;
      endcase
    end
    // an input pin sees a low level from us, never stale latch data
    st_nxt.out_1 = lat_1 & port_1_dir;
    st_nxt.out_2 = lat_2 & port_2_dir;
    st_nxt.out_3 = lat_3 & port_3_dir;
    st_nxt.out_a = lat_a & port_a_dir;
    st_nxt.out_b = lat_b & port_b_dir;
    st_nxt.out_c = lat_c & port_c_dir;
    st_nxt.out_d = lat_d & port_d_dir;
    st_nxt.out_e = lat_e & port_e_dir;
    st_nxt.out_f = lat_f & port_f_dir;
    st_nxt.out_g = lat_g & port_g_dir;
    st_nxt.oe_1 = port_1_dir;
    st_nxt.oe_2 = port_2_dir;
    st_nxt.oe_3 = port_3_dir;
    st_nxt.oe_a = port_a_dir;
    st_nxt.oe_b = port_b_dir;
    st_nxt.oe_c = port_c_dir;
    st_nxt.oe_d = port_d_dir;
    st_nxt.oe_e = port_e_dir;
    st_nxt.oe_f = port_f_dir;
    st_nxt.oe_g = port_g_dir;
    // a pull-up on a driven pin would only waste current
    st_nxt.pu_a = pcr_a & ~port_a_dir;
    st_nxt.pu_b = pcr_b & ~port_b_dir;
    st_nxt.pu_c = pcr_c & ~port_c_dir;
    st_nxt.pu_d = pcr_d & ~port_d_dir;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign port_1_out = st_r.out_1;
  assign port_2_out = st_r.out_2;
  assign port_3_out = st_r.out_3;
  assign port_a_out = st_r.out_a;
  assign port_b_out = st_r.out_b;
  assign port_c_out = st_r.out_c;
  assign port_d_out = st_r.out_d;
  assign port_e_out = st_r.out_e;
  assign port_f_out = st_r.out_f;
  assign port_g_out = st_r.out_g;
  assign port_1_oe = st_r.oe_1;
  assign port_2_oe = st_r.oe_2;
  assign port_3_oe = st_r.oe_3;
  assign port_a_oe = st_r.oe_a;
  assign port_b_oe = st_r.oe_b;
  assign port_c_oe = st_r.oe_c;
  assign port_d_oe = st_r.oe_d;
  assign port_e_oe = st_r.oe_e;
  assign port_f_oe = st_r.oe_f;
  assign port_g_oe = st_r.oe_g;
  assign port_a_pullup_en = st_r.pu_a;
  assign port_b_pullup_en = st_r.pu_b;
  assign port_c_pullup_en = st_r.pu_c;
  assign port_d_pullup_en = st_r.pu_d;

endmodule : port_output_latch_and_pullup_bank

// *** core/unused_placeholder_none.sv ***
/*
  intentionally empty compilation unit is not used.
*/

// *** testbench/port_bank_properties.sv ***
/*
  concurrent checks on the bank's top-level ports.
  assumes one clock, core_clk, and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
module port_bank_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [port_bank_pkg::ADDR_W-1:0] addr,
  input wire logic [port_bank_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [port_bank_pkg::DATA_W-1:0] rdata,
  input wire logic [port_bank_pkg::W_PORT_G-1:0] port_g_pin_in,
  input wire logic [port_bank_pkg::W_PORT_1-1:0] port_1_dir,
  input wire logic [port_bank_pkg::W_PORT_B-1:0] port_b_dir,
  input wire logic [port_bank_pkg::W_PORT_1-1:0] port_1_out,
  input wire logic [port_bank_pkg::W_PORT_B-1:0] port_b_out,
  input wire logic [port_bank_pkg::W_PORT_B-1:0] port_b_oe,
  input wire logic [port_bank_pkg::W_PORT_C-1:0] port_c_oe,
  input wire logic [port_bank_pkg::W_PORT_C-1:0] port_c_pullup_en
);
  import port_bank_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_wr_p2; wr && addr == OFS_PORT_2_OUTPUT_LATCH; endsequence
  sequence s_rd_p2; rd && addr == OFS_PORT_2_OUTPUT_LATCH; endsequence
  sequence s_wr_p1; wr && addr == OFS_PORT_1_OUTPUT_LATCH && port_1_dir == 8'hff; endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_pin_live: assert property ($past(rd) && $past(addr) == OFS_PORT_G_PIN_STATE
    |-> rdata == {3'b000, $past(port_g_pin_in)}) else $error("pin state read wrong");
  a_p3_upper_zero: assert property ($past(rd) && $past(addr) == OFS_PORT_3_OUTPUT_LATCH
    |-> rdata[7:6] == 2'b00) else $error("port 3 upper bits set");
  a_pa_upper_zero: assert property ($past(rd) && $past(addr) == OFS_PORT_A_OUTPUT_LATCH
    |-> rdata[7:4] == 4'h0) else $error("port a upper bits set");
  a_oe_follows_dir: assert property (!$past(reset) |-> port_b_oe == $past(port_b_dir))
    else $error("port b enable wrong");
  a_out_masked: assert property ((port_b_out & ~port_b_oe) == 8'h00)
    else $error("port b drives an input pin");
  a_pullup_masked: assert property ((port_c_pullup_en & port_c_oe) == 8'h00)
    else $error("pull-up on an output pin");
  a_write_readback: assert property (s_wr_p2 ##1 s_rd_p2 |=> rdata == $past(wdata, 2))
    else $error("port 2 readback wrong");
  a_latch_drives: assert property (s_wr_p1 ##1 (port_1_dir == 8'hff && !wr)
    |=> port_1_out == $past(wdata, 2)) else $error("port 1 pins wrong");
endmodule : port_bank_properties

bind port_output_latch_and_pullup_bank port_bank_properties port_bank_properties_i (
  .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .port_g_pin_in(port_g_pin_in), .port_1_dir(port_1_dir),
  .port_b_dir(port_b_dir), .port_1_out(port_1_out), .port_b_out(port_b_out),
  .port_b_oe(port_b_oe), .port_c_oe(port_c_oe), .port_c_pullup_en(port_c_pullup_en));

// *** testbench/port_g_pin_world.sv ***
/*
  outside circuitry on the port g pins: works out each pin's level.
  assumes the bank's out/oe pair per pin and a bench-chosen outside level.
*/
`timescale 1ns/1ps
module port_g_pin_world (
  input wire logic [port_bank_pkg::W_PORT_G-1:0] port_g_out,
  input wire logic [port_bank_pkg::W_PORT_G-1:0] port_g_oe,
  input wire logic [port_bank_pkg::W_PORT_G-1:0] ext_drive,
  output logic [port_bank_pkg::W_PORT_G-1:0] port_g_pin_in
);
  import port_bank_pkg::*;
  // a released pin shows the outside level, never the bank's stale output
  assign port_g_pin_in = (port_g_out & port_g_oe) | (ext_drive & ~port_g_oe);
endmodule : port_g_pin_world

// *** testbench/testbench.sv ***
/*
  self-checking bench: register reset values, readback masks, pin outputs.
  assumes the bank's plain register port and the port g pin model.
*/
`timescale 1ns/1ps
module testbench;
  import port_bank_pkg::*;
  logic core_clk, reset, wr, rd;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, dir8, v, b_out, b_oe, b_pu, d_pu;
  logic [4:0] ext_g, g_pins, g_out, g_oe;
  logic [3:0] a_pu, out_a, oe_a;
  logic [7:0] out_1, out_2, out_c, out_d, out_e, out_f, c_pu;
  logic [7:0] oe_1, oe_2, oe_c, oe_d, oe_e, oe_f;
  logic [5:0] out_3, oe_3;
  logic [15:0] ofs [14];
  logic [7:0] msk [14];
  int err_count, checked, i, p;
  port_output_latch_and_pullup_bank port_output_latch_and_pullup_bank_i (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port_g_pin_in(g_pins), .port_1_dir(dir8), .port_2_dir(dir8),
    .port_3_dir(dir8[5:0]), .port_a_dir(dir8[3:0]), .port_b_dir(dir8), .port_c_dir(dir8),
    .port_d_dir(dir8), .port_e_dir(dir8), .port_f_dir(dir8), .port_g_dir(dir8[4:0]),
    .port_1_out(out_1), .port_2_out(out_2), .port_3_out(out_3), .port_a_out(out_a),
    .port_b_out(b_out), .port_c_out(out_c), .port_d_out(out_d), .port_e_out(out_e),
    .port_f_out(out_f), .port_g_out(g_out), .port_1_oe(oe_1), .port_2_oe(oe_2),
    .port_3_oe(oe_3), .port_a_oe(oe_a), .port_b_oe(b_oe), .port_c_oe(oe_c),
    .port_d_oe(oe_d), .port_e_oe(oe_e), .port_f_oe(oe_f), .port_g_oe(g_oe),
    .port_a_pullup_en(a_pu), .port_b_pullup_en(b_pu), .port_c_pullup_en(c_pu),
    .port_d_pullup_en(d_pu));
  port_g_pin_world port_g_pin_world_i (.port_g_out(g_out), .port_g_oe(g_oe),
    .ext_drive(ext_g), .port_g_pin_in(g_pins));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ends with the strobe low in the edge step, so a read may follow at once
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask : rd_reg

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #(5000 * 20);
    err_count++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    dir8 = 8'hff;
    ext_g = 5'h05;
    err_count = 0;
    checked = 0;
    ofs = '{OFS_PORT_1_OUTPUT_LATCH, OFS_PORT_2_OUTPUT_LATCH, OFS_PORT_3_OUTPUT_LATCH,
      OFS_PORT_A_OUTPUT_LATCH, OFS_PORT_B_OUTPUT_LATCH, OFS_PORT_C_OUTPUT_LATCH,
      OFS_PORT_D_OUTPUT_LATCH, OFS_PORT_E_OUTPUT_LATCH, OFS_PORT_F_OUTPUT_LATCH,
      OFS_PORT_G_OUTPUT_LATCH, OFS_PORT_A_PULLUP_CONTROL, OFS_PORT_B_PULLUP_CONTROL,
      OFS_PORT_C_PULLUP_CONTROL, OFS_PORT_D_PULLUP_CONTROL};
    msk = '{8'hff, 8'hff, 8'h3f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f,
      8'h0f, 8'hff, 8'hff, 8'hff};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 14; i++) begin
      rd_reg(ofs[i], v);
      chk(v, 8'h00);
    end
    // each write is read back in the very next cycle
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 14; i++) begin
        wr_reg(ofs[i], p == 0 ? 8'ha5 : 8'h5a);
        rd_reg(ofs[i], v);
        chk(v, (p == 0 ? 8'ha5 : 8'h5a) & msk[i]);
      end
    end
    wr_reg(16'hff63, 8'hff);
    rd_reg(16'hff63, v);
    chk(v, 8'h00);
    rd_reg(OFS_PORT_1_OUTPUT_LATCH, v);
    chk(v, 8'h5a);
    dir8 <= 8'hf0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(b_out, 8'h50);
    chk(b_oe, 8'hf0);
    chk(b_pu, 8'h0a);
    chk(d_pu, 8'h0a);
    chk({4'h0, a_pu}, 8'h0a);
    chk({3'b000, g_out}, 8'h10);
    chk(out_1, 8'h50);
    chk(out_2, 8'h50);
    chk({2'b00, out_3}, 8'h10);
    chk({4'h0, out_a}, 8'h00);
    chk(out_c, 8'h50);
    chk(out_d, 8'h50);
    chk(out_e, 8'h50);
    chk(out_f, 8'h50);
    // or catches a stray enable, and catches a missing one
    chk(oe_1 | oe_2 | oe_c | oe_d | oe_e | oe_f, 8'hf0);
    chk(oe_1 & oe_2 & oe_c & oe_d & oe_e & oe_f, 8'hf0);
    chk({2'b00, oe_3}, 8'h30);
    chk({4'h0, oe_a}, 8'h00);
    chk({3'b000, g_oe}, 8'h10);
    chk(c_pu, 8'h0a);
    @(posedge core_clk);
    rd_reg(OFS_PORT_G_PIN_STATE, v);
    chk(v, 8'h15);
    wr_reg(OFS_PORT_G_PIN_STATE, 8'hff);
    rd_reg(OFS_PORT_G_PIN_STATE, v);
    chk(v, 8'h15);
    ext_g <= 5'h0a;
    @(posedge core_clk);
    rd_reg(OFS_PORT_G_PIN_STATE, v);
    chk(v, 8'h1a);
    // a second reset must clear latches that now hold written values
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(b_oe, 8'hf0);
    chk(b_out, 8'h00);
    @(posedge core_clk);
    for (i = 0; i < 14; i++) begin
      rd_reg(ofs[i], v);
      chk(v, 8'h00);
    end
    conclude();
  end
endmodule : testbench
